// ==== logic/windowed_watchdog_timer.sv ====
// windowed watchdog timer with classic wishbone register slave
// How it works
// - twelve-bit down counter loaded from reload_value on every reload.
// - counter decrements once per 128 slow-clock ticks via own prescaler.
// - after processor reset reload_value is 0xfff and the timer runs.
// - backup reset sets fault_reset_enable to one.
// - mode register accepts only the first write after processor reset.
// - accepted mode write reloads counter and restarts counting.
// - keyed restart_request inside the window reloads counter and restarts prescaler at once.
// - control writes without key 0xa5 in bits 31:24 are discarded.
// - underflow sets underflow_flag; fault asserted if fault_reset_enable.
// - restart above window limit sets error flag and fault, even disabled.
// - window limit not below reload value allows restart anywhere.
// - interrupt follows flags when fault_irq_enable is one.
// - status read or reset clears flags, interrupt and fault.
// - with fault_reset_enable, fault requests all resets, or processor only when that bit is one.
// - counter halts in debug or idle when the halt bits are set.
// - mode field layout: reload, irq en, rst en, proc, disable, window.
// - status bit 0 sticky underflow, bit 1 sticky restart error.
// - watchdog reset returns flags and mode register to reset values.
// - timer_disable stops the timer; clearing it enables the timer.
//
// The Wishbone interface to the registers is this design's own decision.
`include "wdt_cfg.svh"
`timescale 1ns/1ps
module windowed_watchdog_timer #(
  parameter int CNT_W = 12
) (
  // clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_i,          // processor reset
  input  wire logic        backup_rst_i,   // backup domain reset
  // slow clock tick enable
  input  wire logic        slow_tick_i,
  // processor state
  input  wire logic        debug_i,
  input  wire logic        idle_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // fault and interrupt
  output logic             irq_o,
  output logic             fault_o,
  output logic             fault_all_o,
  output logic             fault_proc_o
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  wdt_pkg::wdt_state_t st;
  wdt_pkg::wdt_state_t next_st;
  logic                rst_en_bkp;   // fault_reset_enable kept in backup domain
  logic                next_rst_en_bkp;

  // access decode
  logic        req;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        rd_flags;
  logic        key_ok;
  logic        restart;
  logic        in_window;
  logic        running;
  logic        halted;
  logic        underflow;
  logic        set_unf;
  logic        set_err;
  logic [11:0] reload_value;
  logic [11:0] restart_window_limit;

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr_ctrl = req && wb_we_i && (wb_adr_i == `WDT_OFS_CTRL) && (&wb_sel_i);
  assign wr_mode = req && wb_we_i && (wb_adr_i == `WDT_OFS_MODE) && (&wb_sel_i);
  assign rd_flags = req && !wb_we_i && (wb_adr_i == `WDT_OFS_FLAGS);
  assign key_ok = (wb_dat_i[`WDT_KEY_HI:`WDT_KEY_LO] == `WDT_KEY);
  assign restart = wr_ctrl && key_ok && wb_dat_i[`WDT_RESTART_BIT];
  assign reload_value = st.mode[`WDT_RELOAD_HI:`WDT_RELOAD_LO];
  assign restart_window_limit = st.mode[`WDT_WIN_HI:`WDT_WIN_LO];
  // window check, open when limit not below reload
  assign in_window = (restart_window_limit >= reload_value)
                  || (st.count <= restart_window_limit);
  assign halted = (debug_i && st.mode[`WDT_DBGHLT_BIT])
               || (idle_i && st.mode[`WDT_IDLEHLT_BIT]);
  assign running = !st.mode[`WDT_DIS_BIT] && !halted;
  // no underflow while disabled
  // only a taken reload or an accepted mode write pre-empts the underflow;
  // an out-of-window restart or a locked mode write leaves the count alone
  assign underflow = running && slow_tick_i && (st.prescale == 7'h7f)
                  && (st.count == 12'h000) && !(restart && in_window)
                  && !(wr_mode && !st.mode_locked);
  assign set_unf = underflow;
  assign set_err = restart && !in_window;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] mode_mix;
    mode_mix = wb_dat_i & `WDT_MODE_MASK;
    next_st = st;
    next_rst_en_bkp = rst_en_bkp;
    next_st.ack = req;
    next_st.rdata = 32'h0000_0000;
    // counter and prescaler
    if (restart && in_window) begin
      next_st.count = reload_value;
      next_st.prescale = 7'h00;
    end else if (wr_mode && !st.mode_locked) begin
      next_st.count = mode_mix[`WDT_RELOAD_HI:`WDT_RELOAD_LO];
      next_st.prescale = 7'h00;
    end else if (running && slow_tick_i) begin
      next_st.prescale = st.prescale + 7'h01;
      if (st.prescale == 7'h7f) begin
        if (st.count == 12'h000) begin
          next_st.count = reload_value;
        end else begin
          next_st.count = st.count - 12'h001;
        end
      end
    end
    if (wr_mode && !st.mode_locked) begin
      next_st.mode = mode_mix;
      next_st.mode_locked = 1'b1;
      next_rst_en_bkp = mode_mix[`WDT_RSTEN_BIT];
    end
    // reads
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `WDT_OFS_MODE: begin
          next_st.rdata = {st.mode[31:14], rst_en_bkp, st.mode[12:0]};
        end
        `WDT_OFS_FLAGS: begin
          next_st.rdata = {30'h0, st.restart_error_flag, st.underflow_flag};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
    // status read clears flags and fault
    if (rd_flags) begin
      next_st.underflow_flag = 1'b0;
      next_st.restart_error_flag = 1'b0;
      next_st.fault = 1'b0;
    end
    // sticky flags, set wins over clear
    if (set_unf) begin
      next_st.underflow_flag = 1'b1;
    end
    if (set_err) begin
      next_st.restart_error_flag = 1'b1;
    end
    if ((set_unf && rst_en_bkp) || set_err) begin
      next_st.fault = 1'b1;
      // reset scope, requested only when fault_reset_enable is one
      // a window error with resets off still shows on fault_o alone
      next_st.fault_all = rst_en_bkp && !st.mode[`WDT_PROC_BIT];
      next_st.fault_proc = rst_en_bkp && st.mode[`WDT_PROC_BIT];
    end else if (rd_flags) begin
      next_st.fault_all = 1'b0;
      next_st.fault_proc = 1'b0;
    end
    next_st.irq = st.mode[`WDT_IRQEN_BIT]
               && (next_st.underflow_flag || next_st.restart_error_flag);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // processor reset restores mode and flags
      st <= '0;
      st.mode <= `WDT_MODE_RESET;
      st.count <= 12'hfff;
    end else begin
      st <= next_st;
    end
  end

  // backup domain bit
  always_ff @(posedge clk_i) begin
    if (backup_rst_i) begin
      // reset enable set by backup reset
      rst_en_bkp <= 1'b1;
    end else begin
      rst_en_bkp <= next_rst_en_bkp;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign irq_o = st.irq;
  assign fault_o = st.fault;
  assign fault_all_o = st.fault_all;
  assign fault_proc_o = st.fault_proc;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // the reset checks look one edge after release, when the reset
  // values must already stand in the state register

  AST_RST_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (st.mode == `WDT_MODE_RESET) && (st.count == 12'hfff))
    else $error("mode or counter not at reset value");

  AST_RST_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> !st.underflow_flag && !st.restart_error_flag && !fault_o
      && !irq_o && !st.mode_locked)
    else $error("reset left flags or fault set");

  AST_BKP: assert property (@(posedge clk_i)
    $past(backup_rst_i) |-> rst_en_bkp)
    else $error("backup reset did not set reset enable");

  AST_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_mode && st.mode_locked) |=> $stable(st.mode))
    else $error("locked mode register changed");

  AST_MODEW: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_mode && !st.mode_locked && !restart) |=> st.count == $past(wb_dat_i[11:0]))
    else $error("mode write did not reload");

  AST_MODE_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (wb_adr_i == `WDT_OFS_MODE)) |=> (wb_dat_o[31:30] == 2'b00))
    else $error("mode readback has reserved bits set");

  AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (wb_adr_i == 4'hc)) |=> (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read returned data");

  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // ------------------------------------------------------------
  // checks: counting
  // ------------------------------------------------------------
  // prescaler steps first
  AST_PRESC: assert property (@(posedge clk_i) disable iff (rst_i)
    (running && slow_tick_i && !restart && !wr_mode && (st.prescale != 7'h7f))
      |=> (st.count == $past(st.count)) && (st.prescale == $past(st.prescale) + 7'h01))
    else $error("counter moved before the prescaler wrapped");

  AST_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
    (running && slow_tick_i && (st.prescale == 7'h7f) && (st.count != 12'h000)
      && !restart && !wr_mode) |=> (st.count == $past(st.count) - 12'h001))
    else $error("counter did not decrement");

  AST_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    underflow |=> (st.count == $past(reload_value)))
    else $error("counter not reloaded after underflow");

  AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
    (restart && in_window) |=> (st.count == $past(reload_value)) && (st.prescale == 7'h00))
    else $error("restart did not reload");

  AST_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    (halted && !restart && !wr_mode) |=> $stable(st.count) && $stable(st.prescale))
    else $error("halted timer counted");

  AST_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.mode[`WDT_DIS_BIT] && !halted && slow_tick_i && !restart && !wr_mode)
      |=> (st.prescale == $past(st.prescale) + 7'h01))
    else $error("enabled timer did not count");

  AST_DIS: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.mode[`WDT_DIS_BIT] && !restart && !wr_mode) |=> $stable(st.count) && !set_unf)
    else $error("disabled timer counted");

  // ------------------------------------------------------------
  // checks: window, flags and fault
  // ------------------------------------------------------------
  // bad key ignored
  AST_BADKEY: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && !key_ok) |=> (st.count == $past(st.count) - 12'h001
      || st.count == $past(st.count) || st.count == $past(reload_value)) && !st.restart_error_flag
      || $past(st.restart_error_flag))
    else $error("bad key write changed state");

  AST_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
    set_err |=> st.restart_error_flag && st.fault)
    else $error("window error not flagged");

  AST_WINOK: assert property (@(posedge clk_i) disable iff (rst_i)
    (restart && (restart_window_limit >= reload_value))
      |=> !st.restart_error_flag || $past(st.restart_error_flag))
    else $error("restart in open window flagged an error");

  AST_UNF: assert property (@(posedge clk_i) disable iff (rst_i)
    set_unf |=> st.underflow_flag && (st.fault == ($past(rst_en_bkp) || $past(st.fault))))
    else $error("underflow handling wrong");

  AST_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    ((st.underflow_flag || st.restart_error_flag) && !rd_flags)
      |=> (st.underflow_flag || !$past(st.underflow_flag))
        && (st.restart_error_flag || !$past(st.restart_error_flag)))
    else $error("sticky flag dropped without a status read");

  AST_RDFLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_flags |=> (wb_dat_o == {30'h0, $past(st.restart_error_flag), $past(st.underflow_flag)}))
    else $error("status read returned wrong flags");

  AST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_flags && !set_unf && !set_err) |=> !st.underflow_flag && !st.restart_error_flag
      && !st.fault ##1 !irq_o)
    else $error("status read did not clear");

  AST_FAULT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_o && !rd_flags) |=> fault_o)
    else $error("fault dropped without a status read");

  AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st.mode[`WDT_IRQEN_BIT] && $stable(st.mode)) |=> !irq_o)
    else $error("interrupt while disabled");

  AST_IRQ_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.mode[`WDT_IRQEN_BIT] && (set_unf || set_err) && !wr_mode) |=> irq_o)
    else $error("fault did not raise the interrupt");

  AST_SCOPE: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_all_o || fault_proc_o) |-> fault_o && !(fault_all_o && fault_proc_o))
    else $error("reset scope inconsistent");

  AST_PROC: assert property (@(posedge clk_i) disable iff (rst_i)
    (set_unf && rst_en_bkp) |=> (fault_all_o == !$past(st.mode[`WDT_PROC_BIT])))
    else $error("reset scope does not follow the processor-only bit");
endmodule : windowed_watchdog_timer

// ==== common/wdt_cfg.svh ====
// constants for the windowed watchdog: offsets, fields, reset values, timing
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_OFS_CTRL      4'h0
`define WDT_OFS_MODE      4'h4
`define WDT_OFS_FLAGS     4'h8
`define WDT_KEY           8'ha5
`define WDT_KEY_HI        31
`define WDT_KEY_LO        24
`define WDT_RESTART_BIT   0
`define WDT_MODE_RESET    32'h3fff2fff
`define WDT_RELOAD_HI     11
`define WDT_RELOAD_LO     0
`define WDT_IRQEN_BIT     12
`define WDT_RSTEN_BIT     13
`define WDT_PROC_BIT      14
`define WDT_DIS_BIT       15
`define WDT_WIN_HI        27
`define WDT_WIN_LO        16
`define WDT_DBGHLT_BIT    28
`define WDT_IDLEHLT_BIT   29
`define WDT_MODE_MASK     32'h3fffffff
`define WDT_UNF_BIT       0
`define WDT_ERR_BIT       1
`define WDT_PRESCALE      128
`endif

// ==== common/wdt_pkg.sv ====
// types for the windowed watchdog
package wdt_pkg;
  typedef struct packed {
    logic [31:0] mode;
    logic        mode_locked;
    logic [11:0] count;
    logic [6:0]  prescale;
    logic        underflow_flag;
    logic        restart_error_flag;
    logic        irq;
    logic        fault;
    logic        fault_all;
    logic        fault_proc;
    logic        ack;
    logic [31:0] rdata;
  } wdt_state_t;
endpackage : wdt_pkg

// ==== testbench/reset_ctrl_model.sv ====
// reset controller model that turns a watchdog fault into a processor reset
`timescale 1ns/1ps
module reset_ctrl_model (
  // clock and requests
  input  wire logic clk_i,
  input  wire logic boot_i,
  input  wire logic fault_i,
  // processor reset
  output logic      rst_o = 1'b1
);
  int wait_q = 0;
  // --------------------------------------------------------------
  // fault honoured a few cycles late so the bench sees it first
  // --------------------------------------------------------------
  // fault resets watchdog
  always @(posedge clk_i) begin
    wait_q <= fault_i ? wait_q + 1 : 0;
    rst_o  <= boot_i || (wait_q >= 4);
  end
endmodule : reset_ctrl_model

// ==== testbench/windowed_watchdog_timer_tb_top.sv ====
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module windowed_watchdog_timer_tb_top;
  logic        clk_i = 1'b0, rst_i, boot = 1'b1, backup_rst_i = 1'b1;
  logic        slow_tick_i = 1'b0, debug_i = 1'b0, idle_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, irq_o, fault_o, fault_all_o, fault_proc_o;
  int          n_errors = 0, compares = 0, cycles = 0;

  windowed_watchdog_timer dut (.clk_i(clk_i), .rst_i(rst_i), .backup_rst_i(backup_rst_i),
    .slow_tick_i(slow_tick_i), .debug_i(debug_i), .idle_i(idle_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .fault_o(fault_o), .fault_all_o(fault_all_o), .fault_proc_o(fault_proc_o));
  // only a fault with a reset scope asks the controller for a reset
  reset_ctrl_model rstc (.clk_i(clk_i), .boot_i(boot), .fault_i(fault_all_o | fault_proc_o),
    .rst_o(rst_i));

  // ------------------------------------------------------------
  // clock, timeout and closing
  // ------------------------------------------------------------
  initial forever #50 clk_i = ~clk_i;
  // ceiling well above the roughly 6700 cycles the run needs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // classic cycle: hold until ack, take data at that edge, then release
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // slow ticks with random gaps; idle wanders since its halt bit stays clear
  task automatic tick(input int n);
    repeat (n) begin
      repeat ($urandom_range(2)) @(posedge clk_i);
      @(posedge clk_i);
      slow_tick_i <= 1'b1;
      idle_i      <= 1'($urandom_range(1));
      @(posedge clk_i);
      slow_tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask : tick

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(24));
    repeat (4) @(posedge clk_i);
    boot         <= 1'b0;
    backup_rst_i <= 1'b0;
    wb(1'b0, `WDT_OFS_MODE, 32'h0);
    check("mode reset", rd, `WDT_MODE_RESET);
    wb(1'b0, 4'hc, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'b1, `WDT_OFS_CTRL, {`WDT_KEY, 24'h1});
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("default window", rd, 32'h0);
    // reload 5, window 1, irq enabled, fault reset off
    wb(1'b1, `WDT_OFS_MODE, 32'h0001_1005);
    wb(1'b1, `WDT_OFS_MODE, 32'h0000_0fff);
    wb(1'b0, `WDT_OFS_MODE, 32'h0);
    check("mode once", rd, 32'h0001_1005);
    wb(1'b1, `WDT_OFS_CTRL, {8'h5a, 24'h1});
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("bad key", rd, 32'h0);
    wb(1'b1, `WDT_OFS_CTRL, {`WDT_KEY, 24'h1});
    repeat (2) @(posedge clk_i);
    check("error irq fault", {30'h0, irq_o, fault_o}, 32'h3);
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("error flag", rd, 32'h2);
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("flags cleared", {rd[29:0], irq_o, fault_o}, 32'h0);
    tick(900);
    check("underflow irq", {30'h0, irq_o, fault_o}, 32'h2);
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("underflow flag", rd, 32'h1);
    // fresh start: reload 1, processor-only fault reset, debug halt
    boot <= 1'b1;
    repeat (2) @(posedge clk_i);
    boot <= 1'b0;
    wb(1'b1, `WDT_OFS_MODE, 32'h1fff_7001);
    debug_i <= 1'b1;
    tick(50);
    debug_i <= 1'b0;
    tick(200);
    wb(1'b1, `WDT_OFS_CTRL, {`WDT_KEY, 24'h1});
    tick(255);
    check("no early fault", {31'h0, fault_o}, 32'h0);
    tick(1);
    check("proc fault", {28'h0, fault_o, fault_all_o, fault_proc_o, irq_o}, 32'hb);
    repeat (10) @(posedge clk_i);
    wb(1'b0, `WDT_OFS_MODE, 32'h0);
    check("mode after fault", rd, `WDT_MODE_RESET);
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("flags after fault", rd, 32'h0);
    // disabled, reload 5, window 1, resets off: error flags, no underflow
    wb(1'b1, `WDT_OFS_MODE, 32'h0001_8005);
    wb(1'b1, `WDT_OFS_CTRL, {`WDT_KEY, 24'h1});
    tick(800);
    check("disabled error", {30'h0, irq_o, fault_o}, 32'h1);
    wb(1'b0, `WDT_OFS_FLAGS, 32'h0);
    check("disabled flags", rd, 32'h2);
    print_verdict();
  end
endmodule : windowed_watchdog_timer_tb_top
